// [rtl/rslbm_pkg.sv]
/*
 * Shared constants and types for the receive status, loop-back and bit monitor block.
 * Assumes a byte-wide register port addressed with 16-bit addresses.
 */
package rslbm_pkg;
    // ==========================================================
    // sizes
    localparam int unsigned NUM_RX        = 8;
    localparam int unsigned NUM_TX        = 4;
    localparam int unsigned NUM_MON       = 8;
    localparam int unsigned WORD_W        = 32;
    localparam int unsigned LABEL_W       = 8;
    localparam int unsigned CNT_W         = 6;
    localparam int unsigned THR_W         = 5;
    localparam int unsigned CHAN_W        = 3;
    localparam int unsigned BSEL_W        = 5;
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 8;

    // ==========================================================
    // register addresses
    localparam logic [15:0] ADDR_FULL       = 16'h8029;
    localparam logic [15:0] ADDR_THR_FLAGS  = 16'h802a;
    localparam logic [15:0] ADDR_MON_VALUE  = 16'h805f;
    localparam logic [15:0] ADDR_MON_CFG    = 16'h8060;
    localparam logic [15:0] ADDR_MON_CFG_HI = 16'h806f;
    localparam logic [15:0] ADDR_THR_VALUE  = 16'h8070;
    localparam logic [15:0] ADDR_MASTER     = 16'h8071;
    localparam logic [15:0] ADDR_LOOPBACK   = 16'h8072;

    // ==========================================================
    // field positions and reset values
    localparam int unsigned MASTER_REV_BIT  = 0;
    localparam int unsigned CR1_CHAN_LSB    = 5;
    localparam int unsigned CR1_BSEL_LSB    = 0;
    localparam int unsigned MON_BIT_MIN     = 8;
    localparam logic [4:0]  THR_RESET       = 5'h10;
    localparam logic [4:0]  THR_NOT_EMPTY   = 5'h00;
    localparam logic [4:0]  THR_FULL_CODE   = 5'h1f;
    localparam logic [5:0]  FIFO_DEPTH      = 6'h20;
    localparam logic [5:0]  CNT_ONE         = 6'h01;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic                valid;
        logic [CHAN_W-1:0]   chan;
        logic [WORD_W-1:0]   data;
    } rslbm_word_t;

    typedef struct packed {
        logic                wr_en;
        logic                rd_en;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } rslbm_reg_req_t;

    typedef struct packed {
        logic [CHAN_W-1:0]   chan;
        logic [BSEL_W-1:0]   bsel;
        logic [LABEL_W-1:0]  label;
    } rslbm_mon_cfg_t;
endpackage

// [rtl/rslbm_top.sv]
/*
 * Receive status flags, loop-back routing, label bit reversal and payload bit monitor pins.
 * Assumes FIFO fill counts come from the FIFO logic, received words arrive one per cycle
 * in bus order (vector bit i = bus bit i+1), and all inputs are synchronous to clk_sys_in.
 */
// Function
// - each FIFO full flag sits at its channel bit, high when holding 32 messages
// - threshold code zero flags one or more messages, code N flags more than N
// - threshold code resets to 10000, flagging above sixteen messages
// - threshold code 11111 flags only at 32 messages, like full
// - a set loop-back bit cuts the receiver from its pins, feeding it from a transmitter
// - transmitter k feeds receivers 2k and 2k+1; select bits reset to zero
// - while looped back, traffic on the receiver's external pins is ignored
// - transmit mask input high disables the transmit output pins
// - a bus word is 8 label bits, 23 data bits, one odd parity bit
// - stored word is little-endian: label byte, bits 9-16, 17-24, 25-32
// - without reversal byte 0 holds bus bit 1 at its MSB
// - reversal flips label bits on receive and again before transmit
// - with reversal on, the flipped label drives matching and storage
// - enabled monitored receiver with target label drives the pin with chosen bit
// - monitor value register mirrors pins, resets zero, updates, accepts host preset
// - all monitor configuration bits clear at reset
// - first config register bits 7:5 choose the watched receive channel
// - bits 4:0 choose payload bit 8 to 31; 0 to 7 have no effect
// - second config register holds the eight-bit target label
// - pins 0 to 7 have identical config register pairs
module rslbm_top #(
    parameter int unsigned NUM_RX = rslbm_pkg::NUM_RX,
    parameter int unsigned NUM_TX = rslbm_pkg::NUM_TX
) (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_n_in,
    input  wire rslbm_pkg::rslbm_reg_req_t     reg_req_in,
    output logic [rslbm_pkg::DATA_W-1:0]       reg_rdata_out,
    input  wire logic [NUM_RX*rslbm_pkg::CNT_W-1:0] fifo_count_in,
    output logic [NUM_RX-1:0]                  queue_full_flag_out,
    output logic [NUM_RX-1:0]                  queue_threshold_flag_out,
    input  wire logic [2*NUM_RX-1:0]           rx_pin_pair_in,
    input  wire logic [2*NUM_TX-1:0]           tx_line_pair_in,
    output logic [2*NUM_RX-1:0]                rx_line_pair_out,
    output logic [2*NUM_TX-1:0]                tx_pin_pair_out,
    input  wire logic                          transmit_output_mask_in,
    input  wire rslbm_pkg::rslbm_word_t        rx_word_in,
    output rslbm_pkg::rslbm_word_t             store_word_out,
    input  wire rslbm_pkg::rslbm_word_t        tx_word_in,
    output rslbm_pkg::rslbm_word_t             tx_bus_word_out,
    input  wire logic [NUM_RX-1:0]             rx_enable_in,
    output logic [rslbm_pkg::NUM_MON-1:0]      bit_monitor_pins_out,
    output logic [NUM_RX-1:0]                  receiver_loopback_select_out,
    output logic                               label_bit_reverse_out
);
    // ==========================================================
    // label byte conversion between bus order and stored order
    function automatic logic [7:0] rslbm_rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    // bus bit 1 lands in stored MSB unless reversed
    function automatic logic [31:0] rslbm_to_store(input logic [31:0] w, input logic rev);
        logic [7:0] lbl;
        lbl = rev ? w[7:0] : rslbm_rev8(w[7:0]);
        return {w[31:8], lbl};
    endfunction

    // ==========================================================
    // control registers
    logic [rslbm_pkg::THR_W-1:0]     thr_code_r;
    logic                            rev_r;
    logic [NUM_RX-1:0]               loop_r;
    logic [rslbm_pkg::NUM_MON-1:0]   mon_val_r;
    logic [rslbm_pkg::NUM_MON-1:0]   mon_val_nxt;
    logic [rslbm_pkg::LABEL_W-1:0]   cr1_r [rslbm_pkg::NUM_MON];
    logic [rslbm_pkg::LABEL_W-1:0]   cr2_r [rslbm_pkg::NUM_MON];
    logic [NUM_RX-1:0]               full_r;
    logic [NUM_RX-1:0]               thr_r;

    logic                            wr_cfg;
    logic [3:0]                      cfg_idx;
    assign wr_cfg  = reg_req_in.wr_en && (reg_req_in.addr >= rslbm_pkg::ADDR_MON_CFG)
                     && (reg_req_in.addr <= rslbm_pkg::ADDR_MON_CFG_HI);
    assign cfg_idx = reg_req_in.addr[3:0];

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            thr_code_r <= rslbm_pkg::THR_RESET;
        end else if (reg_req_in.wr_en && reg_req_in.addr == rslbm_pkg::ADDR_THR_VALUE) begin
            thr_code_r <= reg_req_in.wdata[rslbm_pkg::THR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rev_r <= 1'b0;
        end else if (reg_req_in.wr_en && reg_req_in.addr == rslbm_pkg::ADDR_MASTER) begin
            rev_r <= reg_req_in.wdata[rslbm_pkg::MASTER_REV_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            loop_r <= '0;
        end else if (reg_req_in.wr_en && reg_req_in.addr == rslbm_pkg::ADDR_LOOPBACK) begin
            loop_r <= reg_req_in.wdata[NUM_RX-1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            for (int m = 0; m < rslbm_pkg::NUM_MON; m++) begin
                cr1_r[m] <= rslbm_pkg::BYTE_ZERO;
                cr2_r[m] <= rslbm_pkg::BYTE_ZERO;
            end
        end else if (wr_cfg) begin
            // pair per pin, cr1 at even and cr2 at odd address
            if (cfg_idx[0]) begin
                cr2_r[cfg_idx[3:1]] <= reg_req_in.wdata;
            end else begin
                cr1_r[cfg_idx[3:1]] <= reg_req_in.wdata;
            end
        end
    end

    // ==========================================================
    // fifo status flags
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            full_r <= '0;
            thr_r  <= '0;
        end else begin
            for (int c = 0; c < NUM_RX; c++) begin
                full_r[c] <= (fifo_count_in[c*rslbm_pkg::CNT_W +: rslbm_pkg::CNT_W]
                              >= rslbm_pkg::FIFO_DEPTH);
                if (thr_code_r == rslbm_pkg::THR_NOT_EMPTY) begin
                    thr_r[c] <= (fifo_count_in[c*rslbm_pkg::CNT_W +: rslbm_pkg::CNT_W]
                                 >= rslbm_pkg::CNT_ONE);
                end else if (thr_code_r == rslbm_pkg::THR_FULL_CODE) begin
                    thr_r[c] <= (fifo_count_in[c*rslbm_pkg::CNT_W +: rslbm_pkg::CNT_W]
                                 >= rslbm_pkg::FIFO_DEPTH);
                end else begin
                    thr_r[c] <= (fifo_count_in[c*rslbm_pkg::CNT_W +: rslbm_pkg::CNT_W]
                                 > {1'b0, thr_code_r});
                end
            end
        end
    end

    // ==========================================================
    // loop-back routing and transmit masking
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rx_line_pair_out <= '0;
        end else begin
            for (int r = 0; r < NUM_RX; r++) begin
                // looped receiver fed by its transmitter
                rx_line_pair_out[2*r +: 2] <= loop_r[r] ? tx_line_pair_in[2*(r/2) +: 2]
                                                        : rx_pin_pair_in[2*r +: 2];
            end
        end
    end

    // mask forces the transmit pins to null
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tx_pin_pair_out <= '0;
        end else begin
            tx_pin_pair_out <= transmit_output_mask_in ? '0 : tx_line_pair_in;
        end
    end

    // ==========================================================
    // word storage and transmit ordering
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            store_word_out <= '0;
        end else begin
            store_word_out.valid <= rx_word_in.valid;
            store_word_out.chan  <= rx_word_in.chan;
            store_word_out.data  <= rslbm_to_store(rx_word_in.data, rev_r);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tx_bus_word_out <= '0;
        end else begin
            tx_bus_word_out.valid <= tx_word_in.valid;
            tx_bus_word_out.chan  <= tx_word_in.chan;
            // label, 23 data bits and parity in bus order
            tx_bus_word_out.data  <= rslbm_to_store(tx_word_in.data, rev_r);
        end
    end

    // ==========================================================
    // bit monitor pins
    logic [rslbm_pkg::WORD_W-1:0]  rx_store;
    logic [rslbm_pkg::LABEL_W-1:0] rx_label;
    assign rx_store = rslbm_to_store(rx_word_in.data, rev_r);
    assign rx_label = rx_store[rslbm_pkg::LABEL_W-1:0];

    always_comb begin
        mon_val_nxt = mon_val_r;
        // host preset, hardware update wins below
        if (reg_req_in.wr_en && reg_req_in.addr == rslbm_pkg::ADDR_MON_VALUE) begin
            mon_val_nxt = reg_req_in.wdata;
        end
        for (int m = 0; m < rslbm_pkg::NUM_MON; m++) begin
            // non-matching words leave the pin alone
            if (rx_word_in.valid
                && rx_enable_in[rx_word_in.chan]
                && rx_word_in.chan == cr1_r[m][rslbm_pkg::CR1_CHAN_LSB +: rslbm_pkg::CHAN_W]
                && rx_label == cr2_r[m]
                && cr1_r[m][rslbm_pkg::CR1_BSEL_LSB +: rslbm_pkg::BSEL_W]
                   >= rslbm_pkg::BSEL_W'(rslbm_pkg::MON_BIT_MIN)) begin
                mon_val_nxt[m] = rx_word_in.data[
                    cr1_r[m][rslbm_pkg::CR1_BSEL_LSB +: rslbm_pkg::BSEL_W]];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mon_val_r <= '0;
        end else begin
            mon_val_r <= mon_val_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bit_monitor_pins_out <= '0;
        end else begin
            bit_monitor_pins_out <= mon_val_nxt;
        end
    end

    // ==========================================================
    // status outputs and register read-back
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            queue_full_flag_out          <= '0;
            queue_threshold_flag_out     <= '0;
            receiver_loopback_select_out <= '0;
            label_bit_reverse_out        <= 1'b0;
        end else begin
            queue_full_flag_out          <= full_r;
            queue_threshold_flag_out     <= thr_r;
            receiver_loopback_select_out <= loop_r;
            label_bit_reverse_out        <= rev_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= rslbm_pkg::BYTE_ZERO;
        end else if (reg_req_in.rd_en) begin
            if (reg_req_in.addr >= rslbm_pkg::ADDR_MON_CFG
                && reg_req_in.addr <= rslbm_pkg::ADDR_MON_CFG_HI) begin
                reg_rdata_out <= cfg_idx[0] ? cr2_r[cfg_idx[3:1]] : cr1_r[cfg_idx[3:1]];
            end else begin
                unique case (reg_req_in.addr)
                    rslbm_pkg::ADDR_FULL:      reg_rdata_out <= full_r;
                    rslbm_pkg::ADDR_THR_FLAGS: reg_rdata_out <= thr_r;
                    rslbm_pkg::ADDR_MON_VALUE: reg_rdata_out <= mon_val_r;
                    rslbm_pkg::ADDR_THR_VALUE: reg_rdata_out <= {3'h0, thr_code_r};
                    rslbm_pkg::ADDR_MASTER:    reg_rdata_out <= {7'h00, rev_r};
                    rslbm_pkg::ADDR_LOOPBACK:  reg_rdata_out <= loop_r;
                    default:                   reg_rdata_out <= rslbm_pkg::BYTE_ZERO;
                endcase
            end
        end
    end
endmodule

// [rtl/dummy_placeholder_none.sv]
/*
 * Intentionally empty compilation unit.
 * Assumes nothing.
 */

// [verification/rslbm_properties.sv]
/* checker: port relations of rslbm_top.
   assumes one clock, synchronous active-low reset; bound below. */
module rslbm_properties #(
    parameter int unsigned NUM_RX = rslbm_pkg::NUM_RX,
    parameter int unsigned NUM_TX = rslbm_pkg::NUM_TX
) (
    input wire logic                                clk_sys_in,
    input wire logic                                rst_n_in,
    input wire rslbm_pkg::rslbm_reg_req_t           reg_req_in,
    input wire logic [rslbm_pkg::DATA_W-1:0]        reg_rdata_out,
    input wire logic [NUM_RX*rslbm_pkg::CNT_W-1:0]  fifo_count_in,
    input wire logic [NUM_RX-1:0]                   queue_full_flag_out,
    input wire logic [2*NUM_RX-1:0]                 rx_pin_pair_in,
    input wire logic [2*NUM_TX-1:0]                 tx_line_pair_in,
    input wire logic [2*NUM_RX-1:0]                 rx_line_pair_out,
    input wire logic [2*NUM_TX-1:0]                 tx_pin_pair_out,
    input wire logic                                transmit_output_mask_in,
    input wire rslbm_pkg::rslbm_word_t              rx_word_in,
    input wire rslbm_pkg::rslbm_word_t              store_word_out,
    input wire logic [rslbm_pkg::NUM_MON-1:0]       bit_monitor_pins_out,
    input wire logic [NUM_RX-1:0]                   receiver_loopback_select_out,
    input wire logic                                label_bit_reverse_out
);
    // ==========================================================
    // helpers
    function automatic logic [NUM_RX-1:0] full_of(input logic [NUM_RX*6-1:0] c);
        for (int i = 0; i < NUM_RX; i++)
            full_of[i] = c[6*i+:6] >= rslbm_pkg::FIFO_DEPTH;
    endfunction
    function automatic logic [2*NUM_RX-1:0] loop_of(input logic [NUM_RX-1:0] s,
            input logic [2*NUM_RX-1:0] p, input logic [2*NUM_TX-1:0] t);
        for (int r = 0; r < NUM_RX; r++)
            loop_of[2*r+:2] = s[r] ? t[2*(r/2)+:2] : p[2*r+:2];
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            rev8[i] = b[7-i];
    endfunction

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_full;
        $past(rst_n_in) && $past(rst_n_in, 2) |->
            queue_full_flag_out == full_of($past(fifo_count_in, 2));
    endproperty
    a_full: assert property (p_full) else $error("full flags wrong");
    property p_loop;
        $past(rst_n_in) |-> rx_line_pair_out == loop_of(receiver_loopback_select_out,
            $past(rx_pin_pair_in), $past(tx_line_pair_in));
    endproperty
    a_loop: assert property (p_loop) else $error("loop routing wrong");
    property p_mask;
        $past(rst_n_in) |-> tx_pin_pair_out ==
            ($past(transmit_output_mask_in) ? '0 : $past(tx_line_pair_in));
    endproperty
    a_mask: assert property (p_mask) else $error("transmit pins wrong");
    property p_data;
        rx_word_in.valid |=> store_word_out.data[31:8] == $past(rx_word_in.data[31:8]);
    endproperty
    a_data: assert property (p_data) else $error("data bytes wrong");
    property p_label;
        rx_word_in.valid && !$past(reg_req_in.wr_en) |=> store_word_out.data[7:0] ==
            ($past(label_bit_reverse_out) ? $past(rx_word_in.data[7:0])
                                          : rev8($past(rx_word_in.data[7:0])));
    endproperty
    a_label: assert property (p_label) else $error("label byte wrong");
    property p_mon_hold;
        !rx_word_in.valid && !(reg_req_in.wr_en && reg_req_in.addr == 16'h805f)
            |=> $stable(bit_monitor_pins_out);
    endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("monitor moved");
    property p_rd_full;
        reg_req_in.rd_en && reg_req_in.addr == 16'h8029
            |=> reg_rdata_out == queue_full_flag_out;
    endproperty
    a_rd_full: assert property (p_rd_full) else $error("full read wrong");
    property p_rd_loop;
        reg_req_in.rd_en && reg_req_in.addr == 16'h8072
            |=> reg_rdata_out == receiver_loopback_select_out;
    endproperty
    a_rd_loop: assert property (p_rd_loop) else $error("loop read wrong");
endmodule

bind rslbm_top rslbm_properties #(.NUM_RX(NUM_RX), .NUM_TX(NUM_TX)) u_props (
    .clk_sys_in, .rst_n_in, .reg_req_in, .reg_rdata_out, .fifo_count_in,
    .queue_full_flag_out, .rx_pin_pair_in, .tx_line_pair_in, .rx_line_pair_out,
    .tx_pin_pair_out, .transmit_output_mask_in, .rx_word_in, .store_word_out,
    .bit_monitor_pins_out, .receiver_loopback_select_out, .label_bit_reverse_out);

// [verification/rslbm_line_model.sv]
/* external line receivers and drivers facing the block's pins.
   assumes the bench clock; idle receive lines toggle every cycle. */
module rslbm_line_model (
    input  wire logic        clk_in,
    input  wire logic        send_in,
    input  wire logic [15:0] pattern_in,
    input  wire logic [7:0]  tx_pin_pair_in,
    output logic [15:0]      rx_pin_pair_out = '0,
    output logic             tx_seen_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // bus lines driven
    always @(posedge clk_in)
        rx_pin_pair_out <= send_in ? pattern_in : ~rx_pin_pair_out;
    always @(posedge clk_in)
        tx_seen_out <= |tx_pin_pair_in;
endmodule

// [verification/tb_top.sv]
/* self-checking bench for rslbm_top.
   assumes the checker is bound and the line model stands at the pins. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk_sys_in = 1'b0;
    logic                      rst_n_in = 1'b0;
    rslbm_pkg::rslbm_reg_req_t reg_req_in = '0;
    logic [7:0]                reg_rdata_out;
    logic [47:0]               fifo_count_in = '0;
    logic [7:0]                queue_full_flag_out;
    logic [7:0]                queue_threshold_flag_out;
    logic [15:0]               rx_pin_pair_in;
    logic [7:0]                tx_line_pair_in = '0;
    logic [15:0]               rx_line_pair_out;
    logic [7:0]                tx_pin_pair_out;
    logic                      transmit_output_mask_in = 1'b0;
    rslbm_pkg::rslbm_word_t    rx_word_in = '0;
    rslbm_pkg::rslbm_word_t    store_word_out;
    rslbm_pkg::rslbm_word_t    tx_word_in = '0;
    rslbm_pkg::rslbm_word_t    tx_bus_word_out;
    logic [7:0]                rx_enable_in = '0;
    logic [7:0]                bit_monitor_pins_out;
    logic [7:0]                receiver_loopback_select_out;
    logic                      label_bit_reverse_out;
    logic                      send = 1'b0;
    logic                      seen;
    logic [15:0]               pat = '0;
    int                        n_fail = 0;
    int                        num_checks = 0;

    always #20 clk_sys_in = ~clk_sys_in;

    rslbm_top dut (.clk_sys_in, .rst_n_in, .reg_req_in, .reg_rdata_out, .fifo_count_in,
        .queue_full_flag_out, .queue_threshold_flag_out, .rx_pin_pair_in, .tx_line_pair_in,
        .rx_line_pair_out, .tx_pin_pair_out, .transmit_output_mask_in, .rx_word_in,
        .store_word_out, .tx_word_in, .tx_bus_word_out, .rx_enable_in,
        .bit_monitor_pins_out, .receiver_loopback_select_out, .label_bit_reverse_out);
    rslbm_line_model line_m (.clk_in(clk_sys_in), .send_in(send), .pattern_in(pat),
        .tx_pin_pair_in(tx_pin_pair_out), .rx_pin_pair_out(rx_pin_pair_in), .tx_seen_out(seen));

    // ==========================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_req_in = '{1'b1, 1'b0, a, d};
        tick(1);
        reg_req_in = '0;
        tick(1);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        reg_req_in = '{1'b0, 1'b1, a, 8'h00};
        tick(1);
        chk(reg_rdata_out, e);
        reg_req_in = '0;
        tick(1);
    endtask
    task automatic word(input logic [2:0] c, input logic [31:0] d);
        rx_word_in = '{1'b1, c, d};
        tick(1);
        rx_word_in.valid = 1'b0;
        tick(1);
    endtask
    function automatic logic thr_exp(input logic [4:0] c, input logic [5:0] n);
        if (c == 5'h00)
            return n >= 6'h01;
        if (c == 5'h1f)
            return n >= 6'h20;
        return n > {1'b0, c};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdchk(16'h8070, 8'h10);
        rdchk(16'h8072, 8'h00);
        rdchk(16'h805f, 8'h00);
        rdchk(16'h8060, 8'h00);
        rdchk(16'h806f, 8'h00);
        rdchk(16'h8073, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_flags();
        logic [5:0] n [8] = '{6'h20, 6'h1f, 6'h11, 6'h10, 6'h01, 6'h00, 6'h02, 6'h03};
        logic [4:0] codes [4] = '{5'h10, 5'h00, 5'h1f, 5'h01};
        logic [7:0] e;
        for (int c = 0; c < 8; c++)
            fifo_count_in[6*c+:6] = n[c];
        wr(16'h8029, 8'hff);
        for (int k = 0; k < 4; k++) begin
            if (k > 0)
                wr(16'h8070, {3'h0, codes[k]});
            tick(3);
            for (int c = 0; c < 8; c++)
                e[c] = thr_exp(codes[k], n[c]);
            chk(queue_threshold_flag_out, e);
            rdchk(16'h802a, e);
        end
        chk(queue_full_flag_out, 8'h01);
        rdchk(16'h8029, 8'h01);
        $display("t_flags done");
    endtask
    task automatic t_loop();
        send = 1'b1;
        pat = 16'h9c35;
        tx_line_pair_in = 8'hb4;
        wr(16'h8072, 8'hc1);
        tick(1);
        rdchk(16'h8072, 8'hc1);
        chk(receiver_loopback_select_out, 8'hc1);
        chk(rx_line_pair_out, 16'hac34);
        pat = 16'h635a;
        tick(3);
        chk(rx_line_pair_out, 16'ha358);
        transmit_output_mask_in = 1'b1;
        tick(2);
        chk(tx_pin_pair_out, 8'h00);
        chk(seen, 1'b0);
        transmit_output_mask_in = 1'b0;
        tick(2);
        chk(tx_pin_pair_out, 8'hb4);
        chk(seen, 1'b1);
        wr(16'h8072, 8'h00);
        send = 1'b0;
        $display("t_loop done");
    endtask
    task automatic t_words();
        tx_word_in = '{1'b1, 3'h0, 32'h0000_0080};
        word(3'h2, 32'ha5c3_0f01);
        chk(store_word_out.data, 32'ha5c3_0f80);
        chk(store_word_out.chan, 3'h2);
        chk(tx_bus_word_out.data, 32'h0000_0001);
        wr(16'h8071, 8'h01);
        tick(1);
        chk(label_bit_reverse_out, 1'b1);
        rdchk(16'h8071, 8'h01);
        word(3'h2, 32'h1234_5601);
        chk(store_word_out.data, 32'h1234_5601);
        chk(tx_bus_word_out.data, 32'h0000_0080);
        wr(16'h8071, 8'h00);
        tick(1);
        $display("t_words done");
    endtask
    task automatic t_mon();
        rx_enable_in = 8'h20;
        wr(16'h8066, 8'hac);
        wr(16'h8067, 8'h80);
        rdchk(16'h8067, 8'h80);
        word(3'h5, 32'h0000_1001);
        chk(bit_monitor_pins_out, 8'h08);
        word(3'h4, 32'h0000_0001);
        chk(bit_monitor_pins_out, 8'h08);
        word(3'h5, 32'h0000_0002);
        chk(bit_monitor_pins_out, 8'h08);
        rdchk(16'h805f, 8'h08);
        rx_enable_in = 8'h00;
        word(3'h5, 32'h0000_0001);
        chk(bit_monitor_pins_out, 8'h08);
        rx_enable_in = 8'h20;
        word(3'h5, 32'h0000_0001);
        chk(bit_monitor_pins_out, 8'h00);
        wr(16'h8066, 8'ha5);
        word(3'h5, 32'h0000_0021);
        chk(bit_monitor_pins_out, 8'h00);
        wr(16'h805f, 8'h81);
        chk(bit_monitor_pins_out, 8'h81);
        $display("t_mon done");
    endtask
    task automatic t_rerst();
        rst_n_in = 1'b0;
        tick(2);
        rst_n_in = 1'b1;
        chk(bit_monitor_pins_out, 8'h00);
        rdchk(16'h8066, 8'h00);
        rdchk(16'h8070, 8'h10);
        $display("t_rerst done");
    endtask

    initial begin
        tick(3);
        rst_n_in = 1'b1;
        t_reset();
        t_flags();
        t_loop();
        t_words();
        t_mon();
        t_rerst();
        conclude();
    end
    initial begin
        tick(2000);
        n_fail++;
        conclude();
    end
endmodule
